// File: testbench/aux_readout_loop_tb_top.sv
// Self-checking bench for the auxiliary readout loop.
// Assumes the sensor model answers at address 12h with pulled-up wires.
module aux_readout_loop_tb_top import aux_readout_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int PULSE = 20;
   logic i_clk = 1'b0, i_rstn = 1'b0, i_manual_en = 1'b1, i_aux_en = 1'b0;
   logic [6:0] i_dev_addr = 7'h12;
   logic [7:0] i_read_addr = 8'h10, i_trig_addr = 8'h4C, i_trig_data = 8'h02;
   logic [1:0] i_burst = 2'h3;
   logic [3:0] i_offset = 4'h1;
   logic i_latched = 1'b0, i_int_map = 1'b1, i_update_tick = 1'b0;
   logic i_rd_int_status = 1'b0, i_rd_data = 1'b0;
   logic [63:0] o_data, exp_data;
   logic o_busy, o_drdy_status, o_drdy_int_status, o_int;
   logic o_scl_oe, o_sda_oe, s_oe;
   wire logic scl_w = ~o_scl_oe;
   wire logic sda_w = ~(o_sda_oe | s_oe);
   int errors = 0, n_checks = 0, cyc = 0, n;

   aux_readout_loop #(.PULSE_CYCLES(PULSE), .STEP_CYCLES(50)) dut_u (
      .i_clk(i_clk), .i_rstn(i_rstn), .i_manual_en(i_manual_en),
      .i_aux_en(i_aux_en), .i_dev_addr(i_dev_addr),
      .i_read_addr(i_read_addr), .i_trig_addr(i_trig_addr),
      .i_trig_data(i_trig_data), .i_burst(i_burst), .i_offset(i_offset),
      .i_latched(i_latched), .i_int_map(i_int_map),
      .i_update_tick(i_update_tick), .i_rd_int_status(i_rd_int_status),
      .i_rd_data(i_rd_data), .o_data(o_data), .o_busy(o_busy),
      .o_drdy_status(o_drdy_status), .o_drdy_int_status(o_drdy_int_status),
      .o_int(o_int), .i_scl(scl_w), .o_scl(), .o_scl_oe(o_scl_oe),
      .i_sda(sda_w), .o_sda(), .o_sda_oe(o_sda_oe));
   aux_sensor_model #(.ADDR(7'h12)) sensor_u (
      .scl(scl_w), .sda(sda_w), .sda_oe(s_oe));

   // --------------------------------------------------------------
   // Clock, timeout and reporting
   // --------------------------------------------------------------
   initial forever #2 i_clk = ~i_clk;
   always @(posedge i_clk) begin
      cyc++;
      if (cyc == 160000) begin
         errors++;
         summarize();
      end
   end

   task automatic summarize();
      $display("errors=%0d n_checks=%0d", errors, n_checks);
      if (errors == 0 && n_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : summarize

   task automatic chk(input logic [63:0] got, input logic [63:0] exp,
                      input string what);
      n_checks++;
      if (got !== exp) begin
         errors++;
         $display("MISMATCH t=%0t %s got %h", $time, what, got);
      end
   endtask : chk

   // Bounded wait for busy; a whole read burst fits well inside the bound
   task automatic wait_busy(input logic lvl);
      n = 0;
      while (o_busy !== lvl && n < 90000) begin
         @(negedge i_clk);
         n++;
      end
      chk(n < 90000, 1'b1, "busy wait");
   endtask : wait_busy

   // Publish one sample with an update tick; flags land a cycle later.
   // The loop needs a cycle after busy falls to reach the hold state.
   task automatic publish();
      repeat (2) @(negedge i_clk);
      i_update_tick = 1'b1;
      @(negedge i_clk);
      i_update_tick = 1'b0;
      @(negedge i_clk);
   endtask : publish

   // --------------------------------------------------------------
   // Main sequence
   // --------------------------------------------------------------
   initial begin
      repeat (10) @(negedge i_clk);
      i_rstn = 1'b1;
      @(negedge i_clk);
      chk({o_busy, o_drdy_status, o_int, o_sda_oe}, 0, "reset outputs");
      i_aux_en = 1'b1;
      repeat (300) begin
         @(negedge i_clk);
         chk(o_busy, 1'b0, "busy in manual mode");
      end
      i_manual_en = 1'b0;
      wait_busy(1'b1);
      wait_busy(1'b0);
      chk({sensor_u.wr_reg, sensor_u.wr_dat}, 16'h4C02, "trigger");
      n = 0;
      while (o_busy !== 1'b1 && n < 1000) begin
         @(negedge i_clk);
         n++;
      end
      chk(n >= 50 && n < 100, 1'b1, "offset wait");
      wait_busy(1'b0);
      chk(sensor_u.n_tx, 8, "burst length");
      chk(sensor_u.first_ptr, 8'h10, "read pointer");
      for (int k = 0; k < 8; k++) exp_data[8*k +: 8] = (8'h10 + k) ^ 8'h4B;
      i_burst = 2'h0;
      publish();
      chk(o_data, exp_data, "data bytes");
      chk({o_drdy_status, o_drdy_int_status, o_int}, 3'h7, "flags");
      n = 0;
      while (o_int === 1'b1 && n < 100) begin
         @(negedge i_clk);
         n++;
      end
      chk(n >= PULSE - 1 && n <= PULSE + 1, 1'b1, "pulse width");
      i_rd_int_status = 1'b1;
      @(negedge i_clk);
      i_rd_int_status = 1'b0;
      @(negedge i_clk);
      chk({o_drdy_status, o_drdy_int_status}, 2'h2, "int clear");
      i_rd_data = 1'b1;
      @(negedge i_clk);
      i_rd_data = 1'b0;
      @(negedge i_clk);
      chk(o_drdy_status, 1'b0, "status clear");
      // Second sample: one-byte burst, no offset, latched pin
      i_latched = 1'b1;
      i_offset = 4'h0;
      wait_busy(1'b0);
      n = 0;
      while (o_busy !== 1'b1 && n < 1000) begin
         @(negedge i_clk);
         n++;
      end
      chk(n < 50, 1'b1, "zero offset");
      wait_busy(1'b0);
      chk(sensor_u.n_tx, 1, "short burst");
      exp_data[7:0] = 8'h10 ^ 8'h7B;
      publish();
      chk(o_data, exp_data, "short data");
      repeat (30) @(negedge i_clk);
      chk({o_int, o_drdy_int_status}, 2'h3, "latched pin");
      // Unmapping hides the pin while the status bit stays set
      i_int_map = 1'b0;
      @(negedge i_clk);
      chk({o_int, o_drdy_int_status}, 2'h1, "unmapped pin");
      i_int_map = 1'b1;
      i_rd_int_status = 1'b1;
      @(negedge i_clk);
      i_rd_int_status = 1'b0;
      @(negedge i_clk);
      chk({o_int, o_drdy_int_status}, 2'h0, "latched clear");
      summarize();
   end
endmodule : aux_readout_loop_tb_top

// File: testbench/aux_sensor_model.sv
// Behavioural auxiliary sensor on the two-wire link.
// Assumes pulled-up wires resolved by the bench; it only drives SDA.
module aux_sensor_model #(
   parameter logic [6:0] ADDR = 7'h12
) (
   // Link wires
   input wire logic scl,
   input wire logic sda,
   // Data pull-down
   output logic sda_oe
);
   timeunit 1ns;
   timeprecision 1ps;
   int cnt = 0;
   int ph = 0;
   int n_tx = 0;
   logic [3:0] epoch = 4'h0;
   logic tx = 1'b0;
   logic sel = 1'b0;
   logic [7:0] sr = 8'h00;
   logic [7:0] ptr = 8'h00;
   logic [7:0] first_ptr = 8'h00;
   logic [7:0] wr_reg = 8'h00;
   logic [7:0] wr_dat = 8'h00;
   logic [7:0] cur;
   initial sda_oe = 1'b0;

   // Register content changes per read so stale bytes can be told apart
   function automatic logic [7:0] mem(input logic [7:0] a,
                                      input logic [3:0] e);
      mem = a ^ 8'h5B ^ {e, 4'h0};
   endfunction : mem

   // --------------------------------------------------------------
   // Start condition resets the byte framing
   // --------------------------------------------------------------
   always @(negedge sda) begin
      if (scl === 1'b1) begin
         cnt = 0;
         ph = 0;
         tx = 1'b0;
         sel = 1'b0;
         sda_oe = 1'b0;
      end
   end

   // Sample on the rising clock; never holds SCL low
   // Own address ack is skipped: only the master's ack moves the pointer
   always @(posedge scl) begin
      if (!tx && cnt < 8) sr = {sr[6:0], sda};
      if (tx && cnt == 8 && sda_oe == 1'b0) begin
         n_tx++;
         if (sda === 1'b0) ptr = ptr + 8'h01;
         else tx = 1'b0;
      end
      cnt = cnt + 1;
   end

   // Change SDA only while the clock is low
   always @(negedge scl) begin
      if (cnt == 9) cnt = 0;
      cur = mem(ptr, epoch);
      if (tx) begin
         sda_oe = (cnt < 8) ? ~cur[7 - cnt] : 1'b0;
      end else if (cnt == 8) begin
         case (ph)
            0: begin
               sel = (sr[7:1] == ADDR);
               tx = sel & sr[0];
               if (tx) begin
                  first_ptr = ptr;
                  n_tx = 0;
                  epoch = epoch + 4'h1;
               end
               ph = 1;
            end
            1: begin
               ptr = sr;
               ph = 2;
            end
            default: begin
               wr_reg = ptr;
               wr_dat = sr;
            end
         endcase
         sda_oe = sel;
      end else begin
         sda_oe = 1'b0;
      end
   end
endmodule : aux_sensor_model

// File: verilog/aux_readout_loop.sv
// Autonomous readout loop of the auxiliary sensor link (data mode).
// Assumes the update tick and host read strobes come from same-clock logic;
// SDA comes from a pin and is synchronised here.
//
// Notes on behaviour
// [R1] Loop runs only while manual access is off (data mode); a cycle already begun runs on through S_HOLD to its update tick.
// [R2] Burst starts at the read pointer; bytes land in the eight data bytes.
// [R3] New-sample check uses bit 0 of data byte 6.
// [R4] Data-ready raised each time a new sample set is stored.
// [R5] Non-latched interrupt drops by itself after one 6400 Hz period.
// [R6] Reading interrupt status clears its data-ready bit.
// [R7] Reading the data bytes clears the status data-ready flag.
// [R8] Software maps data-ready to a pin before it can show there.
// [R9] Each cycle writes the trigger address to start a forced measurement.
// [R10] Busy is high for the whole of each link read or write.
// [R11] Offset delay separates measurement trigger from result read.
// [R12] Each sample is one single read transaction of the burst length.
// [R13] Burst code 0b11 reads eight bytes.
// [R14] Bytes beyond a short burst keep undefined (stale) content.
// [R15] Software disables the link while changing read and trigger addresses.
// [R16] Offset of 0 to 37.5 ms chosen by the offset field.
// [R17] Offset zero triggers right after the previous data update.
// [R18] Link clock runs at 400 kHz.
// [R19] Sensor must not stretch the clock; the master never waits on it.
// [R20] A status bit set in the cycle it is read stays set.
// [R21] First received byte goes to data byte 0, then upward.
module aux_readout_loop import aux_readout_pkg::*; #(
   parameter int PULSE_CYCLES = PULSE_CYC,
   parameter int STEP_CYCLES = OFFSET_STEP_CYC
) (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rstn,
   // Configuration bits
   input wire logic i_manual_en,
   input wire logic i_aux_en,
   input wire logic [6:0] i_dev_addr,
   input wire logic [7:0] i_read_addr,
   input wire logic [7:0] i_trig_addr,
   input wire logic [7:0] i_trig_data,
   input wire logic [1:0] i_burst,
   input wire logic [3:0] i_offset,
   input wire logic i_latched,
   input wire logic i_int_map,
   // Host events
   input wire logic i_update_tick,
   input wire logic i_rd_int_status,
   input wire logic i_rd_data,
   // Results
   output logic [63:0] o_data,
   output logic o_busy,
   output logic o_drdy_status,
   output logic o_drdy_int_status,
   output logic o_int,
   // Link pins
   input wire logic i_scl,
   output logic o_scl,
   output logic o_scl_oe,
   input wire logic i_sda,
   output logic o_sda,
   output logic o_sda_oe
);

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   state_e state, next_state;
   logic [4:0] step, next_step;
   logic [1:0] q, next_q;
   logic [3:0] bitn, next_bitn;
   logic [7:0] qcnt, next_qcnt;
   logic [7:0] rx, next_rx;
   logic nack, next_nack;
   logic push_vld, next_push_vld;
   logic [WCNT_W-1:0] wcnt, next_wcnt;
   logic [3:0] nbytes, next_nbytes;
   logic [3:0] widx, next_widx;
   logic pending, next_pending;
   logic [7:0] stage [DATA_BYTES];
   logic [7:0] next_stage [DATA_BYTES];
   logic sda_s1, sda_s2, sda_s3, sda_q, next_sda_q;
   logic [PCNT_W-1:0] pcnt, next_pcnt;
   logic [63:0] next_data;
   logic next_busy, next_drdy, next_ists, next_int;
   logic next_scl_oe, next_sda_oe;
   logic loop_en, stall, publish, txbit;
   logic [7:0] wb;
   sym_e kind;

   byte_stream_if fin ();
   byte_stream_if fout ();

   byte_fifo #(.WIDTH(BYTE_W), .DEPTH(FIFO_DEPTH)) u_fifo (
      .i_clk(i_clk),
      .i_rstn(i_rstn),
      .wr(fin.snk),
      .rd(fout.src)
   );

   // ----------------------------------------------------------------
   // Transaction decode
   // ----------------------------------------------------------------
   // Symbol at a given step of the trigger write or the burst read
   function automatic sym_e sym_of(input state_e st, input logic [4:0] sp,
                                   input logic [3:0] n);
      if (st == S_TRIG) begin
         sym_of = (sp == 5'h00) ? K_START : (sp == 5'h04) ? K_STOP : K_WR;
      end else if (sp == 5'h00 || sp == 5'h03) begin
         sym_of = K_START;
      end else if (sp < 5'h05) begin
         sym_of = K_WR;
      end else if (sp == 5'(n) + 5'h05) begin
         sym_of = K_STOP;
      end else begin
         sym_of = K_RD;
      end
   endfunction : sym_of

   assign loop_en = i_aux_en && !i_manual_en;  // see [R1]
   assign kind = sym_of(state, step, nbytes);  // see [R12]
   assign stall = push_vld && !fin.ready;
   assign fin.valid = push_vld;
   assign fin.data = rx;
   // Hold draining while a finished sample waits to be published
   assign fout.ready = !pending;
   assign publish = (state == S_HOLD) && i_update_tick && pending;

   // Byte sent at each write step
   always_comb begin
      wb = {i_dev_addr, 1'b0};
      if (state == S_TRIG && step == 5'h02) begin
         wb = i_trig_addr;  // see [R9]
      end else if (state == S_TRIG && step == 5'h03) begin
         wb = i_trig_data;
      end else if (state == S_READ && step == 5'h02) begin
         wb = i_read_addr;  // see [R2]
      end else if (state == S_READ && step == 5'h04) begin
         wb = {i_dev_addr, 1'b1};
      end
   end

   // Bit driven now: data, released ack slot, or master ack/nack
   always_comb begin
      if (bitn != 4'h8) begin
         txbit = (kind == K_WR) ? wb[3'(4'h7 - bitn)] : 1'b1;
      end else begin
         txbit = (kind == K_WR) || (step == 5'(nbytes) + 5'h04);
      end
   end

   // ----------------------------------------------------------------
   // Sequencer and link engine
   // ----------------------------------------------------------------
   // Each bit, start or stop is four quarter periods; the sensor may never stretch
   // SCL, so the engine does not look at i_scl
   always_comb begin
      next_state = state;
      next_step = step;
      next_q = q;
      next_bitn = bitn;
      next_qcnt = qcnt;
      next_rx = rx;
      next_nack = nack;
      next_push_vld = push_vld;
      next_wcnt = wcnt;
      next_nbytes = nbytes;
      next_widx = widx;
      next_pending = pending;
      next_stage = stage;
      next_scl_oe = o_scl_oe;
      next_sda_oe = o_sda_oe;
      next_sda_q = (sda_s2 == sda_s3) ? sda_s3 : sda_q;
      if (push_vld && fin.ready) begin
         next_push_vld = 1'b0;
      end
      // Drain in arrival order; short bursts leave the rest stale
      if (fout.valid && fout.ready) begin
         next_stage[widx[2:0]] = fout.data;  // see [R21] see [R14]
         if (widx != 4'(DATA_BYTES - 1)) begin
            next_widx = widx + 4'h1;
         end
      end
      case (state)
         S_IDLE: begin
            if (loop_en) begin
               next_state = S_TRIG;  // see [R17]
               next_step = 5'h00;
               next_nack = 1'b0;
            end
         end
         S_TRIG, S_READ: begin
            if (!stall) begin
               if (qcnt == 8'(QTR_CYC - 1)) begin  // see [R18]
                  next_qcnt = 8'h00;
                  next_q = q + 2'h1;
                  case (q)
                     2'h0: next_sda_oe = (kind == K_START) ? 1'b0 :
                        (kind == K_STOP) ? 1'b1 : !txbit;
                     2'h1: next_scl_oe = 1'b0;
                     2'h2: begin
                        if (kind == K_START) begin
                           next_sda_oe = 1'b1;
                        end else if (kind == K_STOP) begin
                           next_sda_oe = 1'b0;
                        end else if (kind == K_WR && bitn == 4'h8) begin
                           next_nack = nack | sda_q;
                        end else if (kind == K_RD && bitn != 4'h8) begin
                           next_rx = {rx[6:0], sda_q};
                        end
                     end
                     default: begin
                        next_scl_oe = (kind != K_STOP);
                        if ((kind == K_WR || kind == K_RD) &&
                            bitn != 4'h8) begin
                           next_bitn = bitn + 4'h1;
                        end else begin
                           next_bitn = 4'h0;
                           next_step = step + 5'h01;
                           next_push_vld = push_vld | (kind == K_RD);
                           if (kind == K_STOP && state == S_TRIG) begin
                              next_state = S_WAIT;
                              next_wcnt = WCNT_W'(i_offset * STEP_CYCLES);
                           end else if (kind == K_STOP) begin
                              next_state = S_CHECK;
                           end
                        end
                     end
                  endcase
               end else begin
                  next_qcnt = qcnt + 8'h01;
               end
            end
         end
         S_WAIT: begin
            if (wcnt == '0) begin
               next_state = S_READ;  // see [R11] see [R16]
               next_step = 5'h00;
               next_widx = 4'h0;
               next_nbytes = burst_len(i_burst);  // see [R13]
            end else begin
               next_wcnt = wcnt - 1'b1;
            end
         end
         S_CHECK: begin
            if (!fout.valid && !push_vld) begin
               next_pending = !nack && (nbytes <= 4'(DRDY_BYTE) ||
                  stage[DRDY_BYTE][DRDY_BIT]);  // see [R3]
               next_state = S_HOLD;
            end
         end
         default: begin
            if (i_update_tick) begin
               next_pending = 1'b0;
               next_state = loop_en ? S_TRIG : S_IDLE;  // see [R17]
               next_step = 5'h00;
               next_nack = 1'b0;
            end
         end
      endcase
      next_busy = (next_state == S_TRIG) || (next_state == S_READ);
   end

   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         state <= S_IDLE;
         step <= 5'h00;
         q <= 2'h0;
         bitn <= 4'h0;
         qcnt <= 8'h00;
         rx <= BYTE_RST;
         nack <= 1'b0;
         push_vld <= 1'b0;
         wcnt <= '0;
         nbytes <= 4'h8;
         widx <= 4'h0;
         pending <= 1'b0;
         for (int i = 0; i < DATA_BYTES; i++) begin
            stage[i] <= BYTE_RST;
         end
         sda_s1 <= 1'b1;
         sda_s2 <= 1'b1;
         sda_s3 <= 1'b1;
         sda_q <= 1'b1;
         o_busy <= 1'b0;
         o_scl <= 1'b0;
         o_sda <= 1'b0;
         o_scl_oe <= 1'b0;
         o_sda_oe <= 1'b0;
      end else begin
         state <= next_state;
         step <= next_step;
         q <= next_q;
         bitn <= next_bitn;
         qcnt <= next_qcnt;
         rx <= next_rx;
         nack <= next_nack;
         push_vld <= next_push_vld;
         wcnt <= next_wcnt;
         nbytes <= next_nbytes;
         widx <= next_widx;
         pending <= next_pending;
         stage <= next_stage;
         sda_s1 <= i_sda;
         sda_s2 <= sda_s1;
         sda_s3 <= sda_s2;
         sda_q <= next_sda_q;
         o_busy <= next_busy;  // see [R10]
         o_scl_oe <= next_scl_oe;
         o_sda_oe <= next_sda_oe;
      end
   end

   // ----------------------------------------------------------------
   // Data registers and ready flags
   // ----------------------------------------------------------------
   // Set wins over a read-clear in the same cycle, so no sample is lost
   always_comb begin
      for (int i = 0; i < DATA_BYTES; i++) begin
         next_data[i*8 +: 8] = publish ? stage[i] : o_data[i*8 +: 8];
      end
      next_drdy = publish || (o_drdy_status && !i_rd_data);  // see [R7]
      next_ists = publish ||
         (o_drdy_int_status && !i_rd_int_status);  // see [R6] see [R20]
      if (publish) begin
         next_pcnt = PCNT_W'(PULSE_CYCLES);  // see [R5]
      end else if (pcnt != '0) begin
         next_pcnt = pcnt - 1'b1;
      end else begin
         next_pcnt = pcnt;
      end
      // Unmapped interrupt never reaches the pin
      next_int = i_int_map &&
         (i_latched ? next_ists : (next_pcnt != '0));  // see [R8] see [R4]
   end

   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         o_data <= '0;
         o_drdy_status <= 1'b0;
         o_drdy_int_status <= 1'b0;
         o_int <= 1'b0;
         pcnt <= '0;
      end else begin
         o_data <= next_data;  // see [R2]
         o_drdy_status <= next_drdy;
         o_drdy_int_status <= next_ists;
         o_int <= next_int;
         pcnt <= next_pcnt;
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rstn);

   AST_MANUAL_HALTS: assert property ((state == S_IDLE && !loop_en) |=> state == S_IDLE) // see [R1]
      else $error("Loop left idle outside data mode");
   AST_BUSY_SPAN: assert property (o_busy == (state == S_TRIG || state == S_READ)) // see [R10]
      else $error("Busy does not match link activity");
   AST_TRIG_FIRST: assert property ((state == S_IDLE && loop_en) |=> state == S_TRIG ##1 state == S_TRIG) // see [R9]
      else $error("Loop did not begin with trigger write");
   AST_DRDY_BIT: assert property ((state == S_CHECK && !fout.valid && !push_vld && nbytes == 4'h8 && !stage[DRDY_BYTE][DRDY_BIT]) |=> !pending) // see [R3]
      else $error("Sample accepted without ready bit");
   AST_PUBLISH: assert property (publish |=> o_drdy_int_status && o_drdy_status && o_data[7:0] == $past(stage[0])) // see [R4]
      else $error("Published sample not flagged or misplaced");
   AST_PULSE_LEN: assert property (publish |=> pcnt == PCNT_W'(PULSE_CYCLES) ##1 pcnt == PCNT_W'(PULSE_CYCLES - 1)) // see [R5]
      else $error("Non-latched pulse counter wrong");
   AST_INT_CLEAR: assert property ((i_rd_int_status && !publish) |=> !o_drdy_int_status) // see [R6]
      else $error("Interrupt status not cleared by read");
   AST_DATA_CLEAR: assert property ((i_rd_data && !publish) |=> !o_drdy_status) // see [R7]
      else $error("Status flag not cleared by data read");
   AST_SET_WINS: assert property ((publish && i_rd_int_status && i_rd_data) |=> o_drdy_int_status && o_drdy_status) // see [R20]
      else $error("Read-clear beat a new sample");
   AST_WAIT_HOLD: assert property ((state == S_WAIT && wcnt != '0) |=> state == S_WAIT && wcnt == $past(wcnt) - 1'b1) // see [R11]
      else $error("Offset wait cut short");
   AST_QTR_RATE: assert property ((state == S_READ && qcnt == 8'h00 && !stall) |=> qcnt == 8'h01) // see [R18]
      else $error("Quarter timer stalled");

endmodule : aux_readout_loop

// File: verilog/aux_readout_pkg.sv
// Constants, encodings and timing for the auxiliary sensor readout loop.
// Assumes a single 250 MHz system clock; all rates are derived from it.
package aux_readout_pkg;

   // ----------------------------------------------------------------
   // Clock and link timing
   // ----------------------------------------------------------------
   localparam int CLK_NS = 4;
   localparam int SCL_KHZ = 400;
   // Quarter of an SCL period; a least time, so rounded up
   localparam int QTR_NS = 1000000 / SCL_KHZ / 4;
   localparam int QTR_CYC = (QTR_NS + CLK_NS - 1) / CLK_NS;
   // Non-latched interrupt pulse is one period of 6400 Hz
   localparam int PULSE_HZ = 6400;
   localparam int PULSE_NS = 1000000000 / PULSE_HZ;
   localparam int PULSE_CYC = PULSE_NS / CLK_NS;
   // One step of the measurement offset field
   localparam int OFFSET_STEP_US = 2500;
   localparam int OFFSET_STEP_CYC = OFFSET_STEP_US * 1000 / CLK_NS;

   // ----------------------------------------------------------------
   // Widths and sizes
   // ----------------------------------------------------------------
   localparam int BYTE_W = 8;
   localparam int DATA_BYTES = 8;
   localparam int FIFO_DEPTH = 16;
   localparam int WCNT_W = 24;
   localparam int PCNT_W = 16;
   localparam int DRDY_BYTE = 6;
   localparam int DRDY_BIT = 0;
   localparam logic [7:0] BYTE_RST = 8'h00;

   // ----------------------------------------------------------------
   // Encodings
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      S_IDLE, S_TRIG, S_WAIT, S_READ, S_CHECK, S_HOLD
   } state_e;

   typedef enum logic [1:0] {K_START, K_WR, K_RD, K_STOP} sym_e;

   // Burst-length field to byte count
   function automatic logic [3:0] burst_len(input logic [1:0] code);
      case (code)
         2'h0: burst_len = 4'h1;
         2'h1: burst_len = 4'h2;
         2'h2: burst_len = 4'h6;
         default: burst_len = 4'h8;
      endcase
   endfunction : burst_len

endpackage : aux_readout_pkg

// File: verilog/byte_fifo.sv
// Synchronous FIFO with valid/ready on both sides.
// Assumes DEPTH is a power of two and WIDTH matches the stream.
module byte_fifo import aux_readout_pkg::*; #(
   parameter int WIDTH = BYTE_W,
   parameter int DEPTH = FIFO_DEPTH
) (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rstn,
   // Streams
   byte_stream_if.snk wr,
   byte_stream_if.src rd
);
   localparam int AW = $clog2(DEPTH);

   // ----------------------------------------------------------------
   // Storage and pointers
   // ----------------------------------------------------------------
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0] wptr, rptr, next_wptr, next_rptr;
   logic full, empty, push, pop;

   // Extra pointer bit tells full from empty
   assign full = (wptr[AW] != rptr[AW]) && (wptr[AW-1:0] == rptr[AW-1:0]);
   assign empty = (wptr == rptr);
   assign wr.ready = !full;
   assign rd.valid = !empty;
   assign rd.data = mem[rptr[AW-1:0]];
   assign push = wr.valid && !full;
   assign pop = rd.ready && !empty;

   // Pointer advance
   always_comb begin
      next_wptr = wptr;
      next_rptr = rptr;
      if (push) begin
         next_wptr = wptr + 1'b1;
      end
      if (pop) begin
         next_rptr = rptr + 1'b1;
      end
   end

   // Pointer and memory registers
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         wptr <= '0;
         rptr <= '0;
      end else begin
         wptr <= next_wptr;
         rptr <= next_rptr;
         if (push) begin
            mem[wptr[AW-1:0]] <= wr.data;
         end
      end
   end

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rstn);

   AST_FIFO_NO_OVERRUN: assert property ((wr.valid && full) |=> $stable(wptr))
      else $error("FIFO accepted a byte while full");
   AST_FIFO_NO_UNDERRUN: assert property ((rd.ready && empty) |=> $stable(rptr))
      else $error("FIFO popped while empty");

endmodule : byte_fifo

// File: verilog/byte_stream_if.sv
// Valid/ready byte stream between the readout loop and its FIFO.
// Assumes both ends sit on the same clock.
interface byte_stream_if;
   logic [7:0] data;
   logic valid;
   logic ready;
   modport src (output data, output valid, input ready);
   modport snk (input data, input valid, output ready);
endinterface : byte_stream_if
